//--- rtl/dcr_pkg.sv
`default_nettype none

package dcr_pkg;
	localparam int PORTS = 12;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int PRESET_W = 12;
	localparam int TEMP_W = 12;
	localparam int SEQ_W = 8;
	localparam int IDX_W = 4;

	// Register addresses on the serial-interface register port.
	localparam logic [ADDR_W-1:0] ADDR_DEVICE_CONTROL = 8'h01;
	localparam logic [ADDR_W-1:0] ADDR_INPUT_LEVELS = 8'h02;
	localparam logic [ADDR_W-1:0] ADDR_OUTPUT_LEVELS = 8'h03;
	localparam logic [ADDR_W-1:0] ADDR_SHARED_DAC_ONE = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_SHARED_DAC_TWO = 8'h05;
	localparam logic [ADDR_W-1:0] ADC_DATA_BASE = 8'h40;
	localparam logic [ADDR_W-1:0] DAC_DATA_BASE = 8'h60;
	localparam logic [ADDR_W-1:0] PORT_SPAN = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 8'h01;

	localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
	localparam logic [PRESET_W-1:0] PRESET_RESET = 12'h000;
	localparam logic [PORTS-1:0] LEVELS_RESET = 12'h000;
	localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

	localparam logic [1:0] DAC_MODE_PRESET_ONE = 2'h2;
	localparam logic [1:0] DAC_MODE_PRESET_TWO = 2'h3;

	// Level bit layout: ports 0-5 at 7:2, ports 6-10 at 15:11, port 11 at bit 0.
	localparam int LEVEL_LOW_LSB = 2;
	localparam int LEVEL_LOW_PORTS = 6;
	localparam int LEVEL_MID_LSB = 11;
	localparam int LEVEL_MID_PORTS = 5;
	localparam int LEVEL_TOP_BIT = 0;

	localparam int SHUTDOWN_DEGC = 145;
	localparam int TEMP_LSB_PER_DEGC = 8;
	localparam logic signed [TEMP_W-1:0] SHUTDOWN_CODE =
		TEMP_W'(SHUTDOWN_DEGC * TEMP_LSB_PER_DEGC);

	localparam int CLK_PERIOD_PS = 4000;
	localparam int POWER_ON_SEQ_NS = 100;
	localparam int POWER_ON_SEQ_CYCLES =
		(POWER_ON_SEQ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [SEQ_W-1:0] SEQ_LOAD = SEQ_W'(POWER_ON_SEQ_CYCLES - 1);
	localparam logic [SEQ_W-1:0] SEQ_DONE = 8'h00;
	localparam logic [SEQ_W-1:0] SEQ_STEP = 8'h01;

	typedef struct packed {
		logic soft_reset;
		logic burst_address_style;
		logic low_power_select;
		logic series_resistor_cancel;
		logic temperature_conversion_time;
		logic [2:0] temperature_monitor_enables;
		logic thermal_shutdown_enable;
		logic dac_reference_select;
		logic [1:0] adc_rate;
		logic [1:0] dac_update_mode;
		logic [1:0] adc_mode;
	} dcr_ctrl_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} dcr_req_t;

	typedef struct packed {
		logic [PORTS-1:0] digital_input_port;
		logic [PORTS-1:0] digital_output_port;
		logic [PORTS-1:0] adc;
		logic [PORTS-1:0] dac;
	} dcr_modes_t;

	typedef enum logic [3:0] {
		ST_RUN = 4'b0001,
		ST_SEQ = 4'b0010,
		ST_LOWPWR = 4'b0100,
		ST_WAKE = 4'b1000
	} dcr_state_t;

	function automatic logic [DATA_W-1:0] dcr_pack_levels(input logic [PORTS-1:0] p);
		logic [DATA_W-1:0] w;
		w = READ_ZERO;
		w[LEVEL_LOW_LSB +: LEVEL_LOW_PORTS] = p[0 +: LEVEL_LOW_PORTS];
		w[LEVEL_MID_LSB +: LEVEL_MID_PORTS] = p[LEVEL_LOW_PORTS +: LEVEL_MID_PORTS];
		w[LEVEL_TOP_BIT] = p[PORTS-1];
		return w;
	endfunction

	function automatic logic [PORTS-1:0] dcr_unpack_levels(input logic [DATA_W-1:0] w);
		logic [PORTS-1:0] p;
		p[0 +: LEVEL_LOW_PORTS] = w[LEVEL_LOW_LSB +: LEVEL_LOW_PORTS];
		p[LEVEL_LOW_PORTS +: LEVEL_MID_PORTS] = w[LEVEL_MID_LSB +: LEVEL_MID_PORTS];
		p[PORTS-1] = w[LEVEL_TOP_BIT];
		return p;
	endfunction
endpackage

`default_nettype wire

//--- rtl/dcr_sync3.sv
`timescale 1ns/1ps
`default_nettype none

// A bit's level changes only once the second and third stages agree.
module dcr_sync3 #(
	parameter int W = 12
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] level
);
	logic [W-1:0] s1_reg, s2_reg, s3_reg, level_reg, level_next, agree;

	always_comb begin
		agree = ~(s2_reg ^ s3_reg);
		level_next = (agree & s3_reg) | (~agree & level_reg);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			level_reg <= '0;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
		end
	end

	assign level = level_reg;
endmodule

`default_nettype wire

//--- rtl/dcr_burst_step.sv
`timescale 1ns/1ps
`default_nettype none

module dcr_burst_step
	import dcr_pkg::*;
(
	input wire logic [ADDR_W-1:0] cur_addr,
	input wire logic is_write,
	input wire logic burst_style,
	input wire logic [PORTS-1:0] adc_ports,
	input wire logic [PORTS-1:0] dac_ports,
	output logic [ADDR_W-1:0] next_addr
);
	logic in_adc, in_dac;
	logic [PORTS-1:0] mask;
	logic [ADDR_W-1:0] base, idx;

	always_comb begin
		in_adc = (cur_addr >= ADC_DATA_BASE) && (cur_addr < ADC_DATA_BASE + PORT_SPAN);
		in_dac = (cur_addr >= DAC_DATA_BASE) && (cur_addr < DAC_DATA_BASE + PORT_SPAN);
		mask = in_adc ? adc_ports : dac_ports;
		base = in_adc ? ADC_DATA_BASE : DAC_DATA_BASE;
		idx = cur_addr - base;
		next_addr = cur_addr + ADDR_STEP;
		// DAC data reads always step by one, even in contextual style.
		if (burst_style && ((in_adc && !is_write) || (in_dac && is_write))) begin
			// With no matching port left, the burst leaves the data block.
			next_addr = base + PORT_SPAN;
			for (int i = PORTS - 1; i >= 0; i--) begin
				if (ADDR_W'(i) > idx && mask[i]) begin
					next_addr = base + ADDR_W'(i);
				end
			end
		end
	end
endmodule

`default_nettype wire

//--- rtl/dcr_regs.sv
`timescale 1ns/1ps
`default_nettype none

module dcr_regs
	import dcr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire dcr_req_t req,
	output logic [DATA_W-1:0] rd_data,
	output logic rd_valid,
	input wire logic burst_step,
	input wire logic burst_write,
	input wire logic [ADDR_W-1:0] burst_addr,
	output logic [ADDR_W-1:0] burst_next_addr,
	input wire dcr_modes_t modes,
	input wire logic [PORTS-1:0] pin_levels,
	input wire logic temp_valid,
	input wire logic [TEMP_W-1:0] temp_internal,
	output dcr_ctrl_t ctrl_out,
	output logic ports_high_z,
	output logic low_power_active,
	output logic [PORTS-1:0] port_drive_level,
	output logic [PORTS-1:0] port_drive_en,
	output logic dac_preset_active,
	output logic [PRESET_W-1:0] dac_preset_value
);
	localparam int SEQ_BOUND = 40;

	dcr_state_t state_reg, state_next;
	dcr_ctrl_t ctrl_reg, ctrl_next;
	logic [SEQ_W-1:0] seq_reg, seq_next;
	logic [PORTS-1:0] in_levels_reg, in_levels_next;
	logic [PORTS-1:0] out_levels_reg, out_levels_next;
	logic [PRESET_W-1:0] preset1_reg, preset1_next;
	logic [PRESET_W-1:0] preset2_reg, preset2_next;
	logic [DATA_W-1:0] rd_data_reg, rd_data_next;
	logic rd_valid_reg, rd_valid_next;
	logic [ADDR_W-1:0] burst_reg, burst_next;
	logic high_z_reg, high_z_next;
	logic lowpwr_reg, lowpwr_next;
	logic [PORTS-1:0] drive_en_reg, drive_en_next;
	logic preset_on_reg, preset_on_next;
	logic [PRESET_W-1:0] preset_val_reg, preset_val_next;
	logic [PORTS-1:0] pins_synced;
	logic [ADDR_W-1:0] step_addr;
	logic [DATA_W-1:0] wdata;
	logic hot_reset, soft_request, wr_ok;

	assign wdata = req.data;

	dcr_sync3 #(
		.W(PORTS)
	) u_pin_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(pin_levels),
		.level(pins_synced)
	);

	dcr_burst_step u_burst (
		.cur_addr(burst_addr),
		.is_write(burst_write),
		.burst_style(ctrl_reg.burst_address_style),
		.adc_ports(modes.adc),
		.dac_ports(modes.dac),
		.next_addr(step_addr)
	);

	always_comb begin
		hot_reset = ctrl_reg.thermal_shutdown_enable
			&& ctrl_reg.temperature_monitor_enables[0]
			&& temp_valid && ($signed(temp_internal) > SHUTDOWN_CODE);
		wr_ok = req.wr && (state_reg != ST_SEQ);
		soft_request = wr_ok && (req.addr == ADDR_DEVICE_CONTROL) && wdata[DATA_W-1];
		state_next = state_reg;
		ctrl_next = ctrl_reg;
		seq_next = seq_reg;
		out_levels_next = out_levels_reg;
		preset1_next = preset1_reg;
		preset2_next = preset2_reg;
		// Non-input ports read back as zero rather than a stale pin level.
		in_levels_next = pins_synced & modes.digital_input_port;
		burst_next = burst_step ? step_addr : burst_reg;

		case (state_reg)
			ST_RUN: begin
				if (ctrl_reg.low_power_select) begin
					state_next = ST_LOWPWR;
				end
			end
			ST_LOWPWR: begin
				if (!ctrl_reg.low_power_select) begin
					state_next = ST_WAKE;
					seq_next = SEQ_LOAD;
				end
			end
			ST_WAKE: begin
				if (ctrl_reg.low_power_select) begin
					state_next = ST_LOWPWR;
				end else if (seq_reg == SEQ_DONE) begin
					state_next = ST_RUN;
				end else begin
					seq_next = seq_reg - SEQ_STEP;
				end
			end
			ST_SEQ: begin
				if (seq_reg == SEQ_DONE) begin
					state_next = ST_RUN;
					ctrl_next.soft_reset = 1'b0;
				end else begin
					seq_next = seq_reg - SEQ_STEP;
				end
			end
			default: begin
				state_next = ST_SEQ;
				seq_next = SEQ_LOAD;
			end
		endcase

		if (wr_ok) begin
			case (req.addr)
				ADDR_DEVICE_CONTROL: begin
					ctrl_next = dcr_ctrl_t'(wdata);
					// The reset bit is owned by the sequencer; the written bit is dropped here, and a written 1 starts the reset path below.
					ctrl_next.soft_reset = 1'b0;
				end
				ADDR_OUTPUT_LEVELS: begin
					out_levels_next = dcr_unpack_levels(wdata);
				end
				// Only the shared value changes; per-port DAC data lives elsewhere.
				ADDR_SHARED_DAC_ONE: begin
					preset1_next = wdata[PRESET_W-1:0];
				end
				ADDR_SHARED_DAC_TWO: begin
					preset2_next = wdata[PRESET_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// Thermal and soft reset share one path; thermal reset wins over any write.
		if (hot_reset || soft_request) begin
			state_next = ST_SEQ;
			seq_next = SEQ_LOAD;
			ctrl_next = dcr_ctrl_t'(CTRL_RESET);
			ctrl_next.soft_reset = 1'b1;
			out_levels_next = LEVELS_RESET;
			preset1_next = PRESET_RESET;
			preset2_next = PRESET_RESET;
		end

		rd_valid_next = req.rd;
		rd_data_next = READ_ZERO;
		if (req.rd) begin
			case (req.addr)
				ADDR_DEVICE_CONTROL: rd_data_next = ctrl_reg;
				ADDR_INPUT_LEVELS: rd_data_next = dcr_pack_levels(in_levels_reg);
				ADDR_OUTPUT_LEVELS: rd_data_next = dcr_pack_levels(out_levels_reg);
				ADDR_SHARED_DAC_ONE: rd_data_next = DATA_W'(preset1_reg);
				ADDR_SHARED_DAC_TWO: rd_data_next = DATA_W'(preset2_reg);
				default: rd_data_next = READ_ZERO;
			endcase
		end

		high_z_next = (state_next != ST_RUN);
		lowpwr_next = (state_next == ST_LOWPWR);
		// Output bits of other ports are kept but never reach a pin.
		drive_en_next = high_z_next ? LEVELS_RESET : modes.digital_output_port;
		preset_on_next = (ctrl_next.dac_update_mode == DAC_MODE_PRESET_ONE)
			|| (ctrl_next.dac_update_mode == DAC_MODE_PRESET_TWO);
		preset_val_next = (ctrl_next.dac_update_mode == DAC_MODE_PRESET_TWO)
			? preset2_next : preset1_next;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= ST_SEQ;
			ctrl_reg <= dcr_ctrl_t'(CTRL_RESET);
			seq_reg <= SEQ_LOAD;
			in_levels_reg <= LEVELS_RESET;
			out_levels_reg <= LEVELS_RESET;
			preset1_reg <= PRESET_RESET;
			preset2_reg <= PRESET_RESET;
			rd_data_reg <= READ_ZERO;
			rd_valid_reg <= 1'b0;
			burst_reg <= '0;
			high_z_reg <= 1'b1;
			lowpwr_reg <= 1'b0;
			drive_en_reg <= LEVELS_RESET;
			preset_on_reg <= 1'b0;
			preset_val_reg <= PRESET_RESET;
		end else begin
			state_reg <= state_next;
			ctrl_reg <= ctrl_next;
			seq_reg <= seq_next;
			in_levels_reg <= in_levels_next;
			out_levels_reg <= out_levels_next;
			preset1_reg <= preset1_next;
			preset2_reg <= preset2_next;
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
			burst_reg <= burst_next;
			high_z_reg <= high_z_next;
			lowpwr_reg <= lowpwr_next;
			drive_en_reg <= drive_en_next;
			preset_on_reg <= preset_on_next;
			preset_val_reg <= preset_val_next;
		end
	end

	assign rd_data = rd_data_reg;
	assign rd_valid = rd_valid_reg;
	assign burst_next_addr = burst_reg;
	assign ctrl_out = ctrl_reg;
	assign ports_high_z = high_z_reg;
	assign low_power_active = lowpwr_reg;
	assign port_drive_level = out_levels_reg;
	assign port_drive_en = drive_en_reg;
	assign dac_preset_active = preset_on_reg;
	assign dac_preset_value = preset_val_reg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_ctrl_write;
		req.wr && state_reg != ST_SEQ && req.addr == ADDR_DEVICE_CONTROL
			&& !wdata[DATA_W-1] && !hot_reset;
	endsequence

	sequence s_wake_start;
		state_reg == ST_LOWPWR && !ctrl_reg.low_power_select && !hot_reset;
	endsequence

	a_dac_ref_follow: assert property (s_ctrl_write |=>
		ctrl_out.dac_reference_select == $past(wdata[6]))
		else $error("DAC reference select did not follow the control write");

	a_thermal_reset: assert property (hot_reset |=>
		ports_high_z && ctrl_out.soft_reset && port_drive_en == LEVELS_RESET
		&& ctrl_out.thermal_shutdown_enable == 1'b0)
		else $error("Over-temperature did not reset the device");

	a_monitor_enables: assert property (s_ctrl_write |=>
		ctrl_out.temperature_monitor_enables == $past(wdata[10:8]))
		else $error("Monitor enables did not follow the control write");

	a_low_power_hold: assert property (low_power_active |->
		ports_high_z && port_drive_en == LEVELS_RESET)
		else $error("Ports driven during low-power mode");

	a_wake_sequence: assert property (s_wake_start |=>
		ports_high_z [*8])
		else $error("Left low power without the power-on sequence");

	a_soft_reset_clear: assert property (soft_request && !hot_reset |=>
		ctrl_out.soft_reset ##[1:SEQ_BOUND] !ctrl_out.soft_reset)
		else $error("Soft reset bit did not clear itself");

	a_reset_bit_reads: assert property (state_reg != ST_SEQ |->
		!ctrl_out.soft_reset)
		else $error("Soft reset bit set outside the reset sequence");

	a_burst_linear: assert property (burst_step && !ctrl_reg.burst_address_style |=>
		burst_next_addr == $past(burst_addr) + ADDR_STEP)
		else $error("Linear burst did not step by one");

	a_output_store: assert property (req.wr && state_reg != ST_SEQ && !hot_reset
		&& req.addr == ADDR_OUTPUT_LEVELS |=>
		port_drive_level == dcr_unpack_levels($past(wdata)))
		else $error("Output level bits not stored");

	a_preset_two: assert property (ctrl_reg.dac_update_mode == DAC_MODE_PRESET_TWO
		&& $stable(ctrl_reg) && $stable(preset2_reg) |->
		dac_preset_active && dac_preset_value == preset2_reg)
		else $error("Preset mode two did not use shared value two");
endmodule

`default_nettype wire

//--- dv/dcr_host.sv
`timescale 1ns/1ps
`default_nettype none

// Host side of the register port: one access per call, request held for exactly one edge.
module dcr_host
	import dcr_pkg::*;
(
	input wire logic clk,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic rd_valid,
	output dcr_req_t req
);
	initial req = '0;

	// Released address and data lines show the inverse of the last value,
	// so stale data never looks valid.
	task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		output logic v, output logic [DATA_W-1:0] q);
		@(posedge clk);
		req <= '{wr: w, rd: !w, addr: a, data: d};
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
		#1;
		v = rd_valid;
		q = rd_data;
	endtask
endmodule

`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
	import dcr_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic burst_step = 1'b0;
	logic burst_write = 1'b0;
	logic [ADDR_W-1:0] burst_addr = 8'h00;
	dcr_modes_t modes = '0;
	logic [PORTS-1:0] pin_levels = 12'h000;
	logic temp_valid = 1'b0;
	logic [TEMP_W-1:0] temp_internal = 12'h000;
	dcr_req_t req;
	logic [DATA_W-1:0] rd_data;
	logic rd_valid;
	logic [ADDR_W-1:0] burst_next_addr;
	dcr_ctrl_t ctrl_out;
	logic ports_high_z;
	logic low_power_active;
	logic dac_preset_active;
	logic [PORTS-1:0] port_drive_level;
	logic [PORTS-1:0] port_drive_en;
	logic [PRESET_W-1:0] dac_preset_value;
	int n_errors = 0;
	int check_count = 0;
	int n;
	logic v;
	logic [DATA_W-1:0] q;
	logic [DATA_W-1:0] ctrl_m;
	logic [DATA_W-1:0] w;
	logic [PRESET_W-1:0] pre_m [2];
	logic [PORTS-1:0] lv;

	always #2 clk = ~clk;

	dcr_host host (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .req(req));

	dcr_regs dut (.clk(clk), .rst_n(rst_n), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
		.burst_step(burst_step), .burst_write(burst_write), .burst_addr(burst_addr),
		.burst_next_addr(burst_next_addr), .modes(modes), .pin_levels(pin_levels),
		.temp_valid(temp_valid), .temp_internal(temp_internal), .ctrl_out(ctrl_out),
		.ports_high_z(ports_high_z), .low_power_active(low_power_active),
		.port_drive_level(port_drive_level), .port_drive_en(port_drive_en),
		.dac_preset_active(dac_preset_active), .dac_preset_value(dac_preset_value));

	task automatic check(input string name, input logic [DATA_W-1:0] seen,
		input logic [DATA_W-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Bounded wait for the ports to leave high impedance; the count is handed back.
	task automatic wait_run(output int cnt);
		cnt = 0;
		while (ports_high_z !== 1'b0 && cnt < 60) begin
			@(posedge clk);
			#1;
			cnt++;
		end
		if (ports_high_z !== 1'b0) begin
			check("high_z_timeout", {15'h0000, ports_high_z}, 16'h0000);
			final_report();
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		host.access(1'b1, a, d, v, q);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		host.access(1'b0, a, 16'h0000, v, q);
		check("rd_valid", {15'h0000, v}, 16'h0001);
		check("rd_data", q, e);
	endtask

	function automatic int bitpos(input int i);
		return i < 6 ? i + 2 : (i < 11 ? i + 5 : 0);
	endfunction

	function automatic logic [DATA_W-1:0] pk(input logic [PORTS-1:0] p);
		logic [DATA_W-1:0] r;
		r = 16'h0000;
		for (int i = 0; i < PORTS; i++) r[bitpos(i)] = p[i];
		return r;
	endfunction

	// Contextual stepping only for ADC reads at 0x40 and DAC writes at 0x60; all else is linear.
	function automatic logic [ADDR_W-1:0] nxt(input logic [ADDR_W-1:0] a, input logic wrt,
		input logic sty);
		int base;
		logic [PORTS-1:0] m;
		base = wrt ? 8'h60 : 8'h40;
		m = wrt ? modes.dac : modes.adc;
		if (!sty || a < base || a >= base + 12) return a + 8'h01;
		for (int j = a - base + 1; j < PORTS; j++) if (m[j]) return 8'(base + j);
		return 8'(base + 12);
	endfunction

	initial begin
		void'($urandom(66));
		// Every stage, the pin synchroniser too, resets synchronously, so three edges do.
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		wait_run(n);
		check("ctrl_rst", ctrl_out, 16'h0000);
		repeat (6) begin
			w = 16'($urandom) & 16'h5FFF;
			ctrl_m = w;
			wr(ADDR_DEVICE_CONTROL, w);
			check("ctrl", ctrl_out, ctrl_m);
			rd(ADDR_DEVICE_CONTROL, ctrl_m);
		end
		for (int k = 0; k < 2; k++) begin
			w = 16'($urandom);
			pre_m[k] = w[11:0];
			wr(ADDR_SHARED_DAC_ONE + 8'(k), w);
			rd(ADDR_SHARED_DAC_ONE + 8'(k), {4'h0, pre_m[k]});
		end
		for (int md = 0; md < 4; md++) begin
			ctrl_m = (ctrl_m & 16'hFFF3) | 16'(md << 2);
			wr(ADDR_DEVICE_CONTROL, ctrl_m);
			check("preset_active", {15'h0000, dac_preset_active}, 16'(md >= 2));
			check("preset_value", {4'h0, dac_preset_value}, {4'h0, pre_m[md == 3]});
		end
		repeat (4) begin
			@(posedge clk);
			modes.digital_output_port <= 12'($urandom);
			w = 16'($urandom);
			wr(ADDR_OUTPUT_LEVELS, w);
			for (int i = 0; i < PORTS; i++) lv[i] = w[bitpos(i)];
			check("drive_level", {4'h0, port_drive_level}, {4'h0, lv});
			check("drive_en", {4'h0, port_drive_en}, {4'h0, modes.digital_output_port});
			rd(ADDR_OUTPUT_LEVELS, w & 16'hF8FD);
		end
		repeat (4) begin
			@(posedge clk);
			modes.digital_input_port <= 12'($urandom);
			pin_levels <= 12'($urandom);
			repeat (8) @(posedge clk);
			wr(ADDR_INPUT_LEVELS, 16'hFFFF);
			rd(ADDR_INPUT_LEVELS, pk(modes.digital_input_port & pin_levels));
			rd(8'h77, 16'h0000);
		end
		repeat (24) begin
			ctrl_m[14] = 1'($urandom);
			wr(ADDR_DEVICE_CONTROL, ctrl_m);
			@(posedge clk);
			modes.adc <= 12'($urandom);
			modes.dac <= 12'($urandom);
			burst_write <= 1'($urandom);
			burst_addr <= 8'h40 + 8'($urandom % 48);
			burst_step <= 1'b1;
			@(posedge clk);
			burst_step <= 1'b0;
			#1;
			q = {8'h00, nxt(burst_addr, burst_write, ctrl_m[14])};
			check("burst", {8'h00, burst_next_addr}, q);
		end
		wr(ADDR_DEVICE_CONTROL, ctrl_m | 16'h2000);
		@(posedge clk);
		#1;
		check("low_power", {15'h0000, low_power_active}, 16'h0001);
		check("high_z_lp", {15'h0000, ports_high_z}, 16'h0001);
		check("drive_en_lp", {4'h0, port_drive_en}, 16'h0000);
		wr(ADDR_DEVICE_CONTROL, ctrl_m);
		check("high_z_wake", {15'h0000, ports_high_z}, 16'h0001);
		wait_run(n);
		// One edge to leave low power, then the full power-on sequence.
		check("wake_len", 16'(n), 16'(POWER_ON_SEQ_CYCLES + 1));
		check("low_power_off", {15'h0000, low_power_active}, 16'h0000);
		wr(ADDR_DEVICE_CONTROL, ctrl_m & 16'h7FFF);
		check("ctrl_zero15", ctrl_out, ctrl_m);
		check("high_z_zero15", {15'h0000, ports_high_z}, 16'h0000);
		wr(ADDR_DEVICE_CONTROL, ctrl_m | 16'h8000);
		check("ctrl_soft", ctrl_out, 16'h8000);
		check("level_soft", {4'h0, port_drive_level}, 16'h0000);
		rd(ADDR_DEVICE_CONTROL, 16'h8000);
		wait_run(n);
		rd(ADDR_DEVICE_CONTROL, 16'h0000);
		rd(ADDR_SHARED_DAC_TWO, 16'h0000);
		for (int k = 0; k < 3; k++) begin
			w = (k == 1) ? 16'h0080 : 16'h0180;
			wr(ADDR_DEVICE_CONTROL, w);
			@(posedge clk);
			temp_valid <= 1'b1;
			temp_internal <= 12'(145 * 8 + (k > 0));
			@(posedge clk);
			temp_valid <= 1'b0;
			#1;
			check("thermal", ctrl_out, (k == 2) ? 16'h8000 : w);
			wait_run(n);
		end
		final_report();
	end
endmodule

`default_nettype wire
